//--- rtl/lacc_core.sv
// Load adaptive current regulator core
`timescale 1ns/1ps
`include "lacc_consts.svh"
module lacc_core
	import lacc_pkg::*;
(
	input  wire logic                    ref_clk_in,
	input  wire logic                    resetn_in,
	input  wire logic                    meas_valid_in,
	input  wire logic [`LACC_LOAD_W-1:0] load_measurement_value_in,
	input  wire logic                    filter_enable_in,
	input  wire logic                    velocity_above_lower_in,
	input  wire logic                    velocity_below_upper_in,
	input  wire logic [3:0]              lower_load_threshold_field_in,
	input  wire logic [3:0]              upper_load_hysteresis_field_in,
	input  wire logic [1:0]              current_increment_step_in,
	input  wire logic [1:0]              current_decrement_rate_in,
	input  wire logic                    min_current_quarter_in,
	input  wire logic [`LACC_CS_W-1:0]   run_current_scale_in,
	output logic      [`LACC_LOAD_W-1:0] load_value_out,
	output logic                         load_update_out,
	output logic                         stall_out,
	output logic                         regulation_active_out,
	output logic      [`LACC_CS_W-1:0]   actual_current_scale_out
);

	// ------------------------------------------------------------
	// Window, thresholds and limits
	// ------------------------------------------------------------
	logic                      win_en;
	logic                      reg_en;
	logic [`LACC_LOAD_W:0]     lo_thr;
	logic [`LACC_LOAD_W:0]     hi_thr;
	logic [`LACC_LOAD_W-1:0]   cur_load;
	logic                      cur_valid;
	lacc_cs_t                  cs_min;
	lacc_cs_t                  cs_r;
	lacc_cs_t                  cs_nxt;
	lacc_hit_t                 hit_r;
	lacc_hit_t                 hit_nxt;
	lacc_hit_t                 hit_need;
	logic [3:0]                inc_step;
	logic [`LACC_LOAD_W-1:0]   load_r;
	logic [`LACC_LOAD_W-1:0]   load_nxt;
	logic                      upd_r;
	logic                      upd_nxt;
	logic [`LACC_LOAD_W+1:0]   acc_r;
	logic [`LACC_LOAD_W+1:0]   acc_nxt;
	logic [1:0]                cnt_r;
	logic [1:0]                cnt_nxt;

	assign win_en = velocity_above_lower_in & velocity_below_upper_in;
	assign reg_en = win_en & (lower_load_threshold_field_in != 4'h0);
	assign lo_thr = {2'h0, lower_load_threshold_field_in, 5'h00};
	assign hi_thr = {1'b0, ({1'b0, lower_load_threshold_field_in}
		+ {1'b0, upper_load_hysteresis_field_in} + 5'h01), 5'h00};
	assign cs_min = min_current_quarter_in ? (run_current_scale_in >> 2)
		: (run_current_scale_in >> 1);
	assign inc_step = 4'h1 << current_increment_step_in;

	always_comb
	begin
		unique case (current_decrement_rate_in)
			2'h0: hit_need = 6'h20;
			2'h1: hit_need = 6'h08;
			2'h2: hit_need = 6'h02;
			2'h3: hit_need = 6'h01;
		endcase
	end

	// ------------------------------------------------------------
	// Load measurement and filter
	// ------------------------------------------------------------
	// raw per step, or average of four
	always_comb
	begin
		load_nxt  = load_r;
		upd_nxt   = 1'b0;
		acc_nxt   = acc_r;
		cnt_nxt   = cnt_r;
		cur_valid = 1'b0;
		cur_load  = load_r;
		if (meas_valid_in)
		begin
			if (!filter_enable_in)
			begin
				cur_valid = 1'b1;
				cur_load  = load_measurement_value_in;
				acc_nxt   = '0;
				cnt_nxt   = 2'h0;
			end
			else if (cnt_r == 2'h3)
			begin
				cur_valid = 1'b1;
				cur_load  = 10'((acc_r + {2'h0, load_measurement_value_in})
					>> `LACC_FILT_SHIFT);
				acc_nxt   = '0;
				cnt_nxt   = 2'h0;
			end
			else
			begin
				acc_nxt = acc_r + {2'h0, load_measurement_value_in};
				cnt_nxt = cnt_r + 2'h1;
			end
		end
		if (cur_valid)
		begin
			load_nxt = cur_load;
			upd_nxt  = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!resetn_in)
		begin
			load_r <= '0;
			upd_r  <= 1'b0;
			acc_r  <= '0;
			cnt_r  <= 2'h0;
		end
		else
		begin
			load_r <= load_nxt;
			upd_r  <= upd_nxt;
			acc_r  <= acc_nxt;
			cnt_r  <= cnt_nxt;
		end
	end

	// ------------------------------------------------------------
	// Current scale regulation
	// ------------------------------------------------------------
	// Outside the window the scale returns to run current, as at rest
	always_comb
	begin
		cs_nxt  = cs_r;
		hit_nxt = hit_r;
		if (!reg_en)
		begin
			cs_nxt  = run_current_scale_in;
			hit_nxt = '0;
		end
		else
		begin
			if (cs_r > run_current_scale_in)
				cs_nxt = run_current_scale_in;
			else if (cs_r < cs_min)
				cs_nxt = cs_min;
			if (cur_valid)
			begin
				// Step from the clamped scale, so a new limit never escapes
				if ({1'b0, cur_load} < lo_thr)
				begin
					hit_nxt = '0;
					if ({1'b0, cs_nxt} + {2'h0, inc_step}
						>= {1'b0, run_current_scale_in})
						cs_nxt = run_current_scale_in;
					else
						cs_nxt = 5'(cs_nxt + {1'b0, inc_step});
				end
				else if ({1'b0, cur_load} >= hi_thr)
				begin
					if (hit_r + 6'h01 >= hit_need)
					begin
						hit_nxt = '0;
						if (cs_nxt > cs_min)
							cs_nxt = cs_nxt - 5'h01;
					end
					else
						hit_nxt = hit_r + 6'h01;
				end
				else
					hit_nxt = '0;
			end
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!resetn_in)
		begin
			cs_r  <= `LACC_CS_RESET;
			hit_r <= '0;
		end
		else
		begin
			cs_r  <= cs_nxt;
			hit_r <= hit_nxt;
		end
	end

	assign actual_current_scale_out = cs_r;
	assign load_value_out           = load_r;
	assign load_update_out          = upd_r;
	assign regulation_active_out    = reg_en;
	assign stall_out = win_en & upd_r & (load_r == '0);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);

	window_gate_a: assert property (
		!win_en |-> !stall_out ##1 cs_r == $past(run_current_scale_in))
		else $error("regulation active outside window");
	zero_field_a: assert property (
		lower_load_threshold_field_in == 4'h0 |=>
		cs_r == $past(run_current_scale_in))
		else $error("zero lower field did not disable");
	raw_update_a: assert property (
		meas_valid_in && !filter_enable_in |=>
		upd_r && load_r == $past(load_measurement_value_in))
		else $error("raw load not refreshed");
	filter_hold_a: assert property (
		meas_valid_in && filter_enable_in && cnt_r != 2'h3 |=> !upd_r)
		else $error("filter reported early");
	raise_step_a: assert property (
		reg_en && cur_valid && {1'b0, cur_load} < lo_thr
		&& cs_r >= cs_min && {1'b0, cs_r} + {2'h0, inc_step}
		< {1'b0, run_current_scale_in} && $stable(run_current_scale_in)
		|=> cs_r == $past(cs_r) + {1'b0, $past(inc_step)})
		else $error("wrong increment");
	low_thr_a: assert property (
		lo_thr[4:0] == 5'h00 && lo_thr < 11'h200)
		else $error("lower threshold out of range");
	hi_thr_a: assert property (
		hi_thr == 11'(({7'h0, lower_load_threshold_field_in}
		+ {7'h0, upper_load_hysteresis_field_in} + 11'h001) * 11'h020))
		else $error("upper threshold mismatch");
	hit_clear_a: assert property (
		reg_en && cur_valid && {1'b0, cur_load} < hi_thr |=> hit_r == '0)
		else $error("high count not cleared");
	dec_rate_a: assert property (
		reg_en && cs_r >= cs_min && cs_r <= run_current_scale_in
		&& cs_nxt < cs_r |-> cur_valid && {1'b0, cur_load} >= hi_thr
		&& hit_r + 6'h01 >= hit_need ##1 hit_r == '0)
		else $error("decrement without enough high samples");
	scale_max_a: assert property (
		$stable(run_current_scale_in) && $stable(reg_en)
		[*2] |-> cs_r <= run_current_scale_in)
		else $error("scale above run current");

	cov_raise_c: cover property (reg_en && cur_valid
		&& {1'b0, cur_load} < lo_thr);
	cov_lower_c: cover property (reg_en && cs_nxt < cs_r);
	cov_filt_c: cover property (filter_enable_in && upd_r);
	cov_stall_c: cover property (stall_out);

endmodule : lacc_core

//--- rtl/lacc_consts.svh
// Constants for the load adaptive current control block
`ifndef LACC_CONSTS_SVH
`define LACC_CONSTS_SVH
`define LACC_LOAD_W       10
`define LACC_FIELD_W      4
`define LACC_CS_W         5
`define LACC_THR_SHIFT    5
`define LACC_FILT_DEPTH   4
`define LACC_FILT_SHIFT   2
`define LACC_CS_RESET     5'h1F
`define LACC_HIT_W        6
`endif

//--- rtl/lacc_pkg.sv
// Types for the load adaptive current control block
`include "lacc_consts.svh"
package lacc_pkg;
	typedef logic [`LACC_LOAD_W-1:0] lacc_load_t;
	typedef logic [`LACC_CS_W-1:0]   lacc_cs_t;
	typedef logic [`LACC_HIT_W-1:0]  lacc_hit_t;
endpackage : lacc_pkg

//--- dv/lacc_ctrl_model.sv
// Motion controller model that issues steps and stops on stall
`timescale 1ns/1ps
module lacc_ctrl_model
	import lacc_pkg::*;
(
	input  wire logic       ref_clk_in,
	input  wire logic       resetn_in,
	input  wire logic       step_req_in,
	input  wire lacc_load_t step_load_in,
	input  wire logic       stall_in,
	output logic            meas_valid_out,
	output lacc_load_t      load_out,
	output logic            stopped_out
);
	lacc_load_t last_r;
	always_ff @(posedge ref_clk_in)
	begin
		if (!resetn_in)
			stopped_out <= 1'b0;
		else if (stall_in)
			stopped_out <= 1'b1;
		if (meas_valid_out)
			last_r <= load_out;
	end
	// Idle bus shows no stale value
	assign meas_valid_out = step_req_in & ~stopped_out;
	assign load_out = meas_valid_out ? step_load_in : ~last_r;
endmodule : lacc_ctrl_model

//--- dv/load_adaptive_current_control_tb.sv
// Self-checking bench for the load adaptive current regulator
`timescale 1ns/1ps
`include "lacc_consts.svh"
module load_adaptive_current_control_tb
	import lacc_pkg::*;
;
	typedef struct packed {lacc_load_t ld; lacc_cs_t cs; logic st;} lacc_exp_t;
	logic       ref_clk = 0, resetn = 0, req = 0, filt = 0, vlo = 0, vhi = 0;
	logic       quarter = 0, valid, upd, stall, act, stopped;
	lacc_load_t sload = 0, ld_in, ld_out;
	logic [3:0] fld = 0, hys = 0;
	logic [1:0] inc = 0, dec = 0;
	lacc_cs_t   run = 0, cs_out;
	int         mismatches, checks;
	integer     seed = 32'h61949f55;
	int         cs, cnt, sum, nf, k, lo, hi, r;
	int unsigned x;
	bit         exp_stop;
	lacc_exp_t  q[$], e;

	always #2 ref_clk = ~ref_clk;

	lacc_core i_dut (.ref_clk_in(ref_clk), .resetn_in(resetn),
		.meas_valid_in(valid), .load_measurement_value_in(ld_in),
		.filter_enable_in(filt), .velocity_above_lower_in(vlo),
		.velocity_below_upper_in(vhi), .lower_load_threshold_field_in(fld),
		.upper_load_hysteresis_field_in(hys),
		.current_increment_step_in(inc), .current_decrement_rate_in(dec),
		.min_current_quarter_in(quarter), .run_current_scale_in(run),
		.load_value_out(ld_out), .load_update_out(upd), .stall_out(stall),
		.regulation_active_out(act), .actual_current_scale_out(cs_out));
	lacc_ctrl_model i_ctrl (.ref_clk_in(ref_clk), .resetn_in(resetn),
		.step_req_in(req), .step_load_in(sload), .stall_in(stall),
		.meas_valid_out(valid), .load_out(ld_in), .stopped_out(stopped));

	task automatic fail(input string m);
		mismatches++;
		$display("CHECK FAILED %0t %s", $time, m);
	endtask : fail

	task automatic finish_test();
		if (mismatches == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	// Reference regulator, one call per reported value
	task automatic regulate(input int v);
		int l, h, mn, n;
		l = fld * 32;
		h = (fld + hys + 1) * 32;
		mn = quarter ? run >> 2 : run >> 1;
		n = (dec == 0) ? 32 : (dec == 1) ? 8 : (dec == 2) ? 2 : 1;
		if (!(vlo && vhi) || fld == 0)
			cnt = 0;
		else if (v < l)
		begin
			cs = (cs + (1 << inc) > run) ? run : cs + (1 << inc);
			cnt = 0;
		end
		else if (v >= h)
			cnt++;
		else
			cnt = 0;
		if (cnt >= n)
		begin
			cnt = 0;
			cs = (cs > mn) ? cs - 1 : mn;
		end
		q.push_back('{lacc_load_t'(v), lacc_cs_t'(cs), vlo && vhi && v == 0});
		exp_stop = exp_stop || (vlo && vhi && v == 0);
	endtask : regulate

	task automatic step(input int v);
		@(posedge ref_clk) #1;
		req = 1'b1;
		sload = lacc_load_t'(v);
		@(posedge ref_clk) #1;
		req = 1'b0;
		if (exp_stop)
			return;
		sum += v;
		nf++;
		if (!filt)
			regulate(v);
		else if (nf == 4)
			regulate(sum >> 2);
		if (!filt || nf == 4)
		begin
			sum = 0;
			nf = 0;
		end
	endtask : step

	task automatic do_reset();
		@(posedge ref_clk) #1;
		resetn = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		exp_stop = 0;
		checks++;
		if (cs_out !== `LACC_CS_RESET || ld_out !== 10'h000) fail("reset");
	endtask : do_reset

	task automatic setup(input int c);
		@(posedge ref_clk) #1;
		vlo = 1'b0;
		vhi = 1'b1;
		filt = 1'b0;
		fld = 4'(1 + $unsigned($random(seed)) % 15);
		hys = 4'($random(seed));
		inc = 2'(c);
		dec = 2'(c >> 2);
		quarter = c[0] ^ c[2];
		run = 5'(8 + $unsigned($random(seed)) % 24);
		repeat (2) @(posedge ref_clk);
		#1;
		checks++;
		if (cs_out !== run) fail("scale outside window");
		filt = c[3];
		vlo = 1'b1;
		vhi = (c != 16);
		fld = (c == 17) ? 4'h0 : fld;
		cs = run;
		{cnt, sum, nf} = 0;
		repeat (2) @(posedge ref_clk);
		#1;
		checks++;
		if (act !== (vhi && fld != 0)) fail("regulation active");
	endtask : setup

	always @(negedge ref_clk)
		if (upd === 1'b1)
		begin
			checks++;
			if (q.size() == 0)
				fail("unexpected update");
			else
			begin
				e = q.pop_front();
				if (ld_out !== e.ld) fail("load value");
				if (cs_out !== e.cs) fail("scale");
				if (stall !== e.st) fail("stall");
			end
		end

	initial
	begin
		#100000;
		fail("timeout");
		finish_test();
	end

	initial
	begin
		do_reset();
		for (k = 0; k < 18; k++)
		begin
			setup(k);
			lo = fld ? fld * 32 : 32;
			hi = (fld + hys + 1) * 32;
			repeat (80)
			begin
				r = $unsigned($random(seed)) % 10;
				x = $unsigned($random(seed));
				step((r < 2) ? 1 + x % (lo + 1) : (r < 7) ? hi + x % (1024 - hi) :
					(r == 7) ? hi : (r == 8) ? lo : lo + x % (hi - lo + 1));
			end
			if (k == 16)
				step(0);
		end
		do_reset();
		setup(18);
		step(0);
		step(500);
		repeat (3) @(posedge ref_clk);
		checks++;
		if (stopped !== 1'b1 || q.size() != 0) fail("stop on stall");
		finish_test();
	end
endmodule : load_adaptive_current_control_tb
